// file: dv/io_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module io_cfg_props (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        cfg_write,
   input wire logic [7:0]  cfg_sub_addr,
   input wire logic [15:0] cfg_write_data,
   input wire logic [11:0] gpio_data,
   input wire logic [11:0] pin_in,
   input wire logic [11:0] pin_out,
   input wire logic [11:0] pin_oe,
   input wire logic        adc_busy,
   input wire logic        alarm_a,
   input wire logic        alarm_b,
   input wire logic        dac_load_strobe_in,
   input wire logic [1:0]  dac_off_pull,
   input wire logic        ext_ref_sel
);
   logic [15:0] drv, fnc, gen;
   logic [1:0]  q;
   wire  [11:0] alt = ~fnc[11:0] & 12'h05f;
   // Shadow of written settings, cycles since the last write
   always_ff @(posedge ref_clk) begin
      if (reset) {drv, fnc, gen, q} <= '0;
      else begin
         q <= cfg_write ? 2'h0 : q + {1'b0, q != 2'h3};
         if (cfg_write && cfg_sub_addr == 8'h01) drv <= cfg_write_data;
         if (cfg_write && cfg_sub_addr == 8'h02) fnc <= cfg_write_data;
         if (cfg_write && cfg_sub_addr == 8'h08) gen <= cfg_write_data;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   oe_enable_a: assert property (q == 2'h3 |-> pin_oe == (drv[11:0] & ~(alt & 12'h01c)))
      else $error("pin_oe wrong");
   gpio_level_a: assert property (q == 2'h3 |->
      ((pin_out ^ $past(gpio_data)) & drv[11:0] & ~alt) == 12'h000) else $error("gpio wrong");
   busy_pin_a: assert property (q == 2'h3 && !fnc[6] |-> pin_out[6] == $past(adc_busy))
      else $error("busy pin wrong");
   alarm_pol_a: assert property (q == 2'h3 && !fnc[0] |->
      pin_out[0] == ($past(alarm_a) ~^ gen[4])) else $error("alarm pin wrong");
   alarm_b_pol_a: assert property (q == 2'h3 && !fnc[1] |->
      pin_out[1] == ($past(alarm_b) ~^ gen[5])) else $error("alarm b pin wrong");
   load_in_a: assert property (q == 2'h3 |->
      dac_load_strobe_in == (!fnc[3] && $past(pin_in[3]))) else $error("load wrong");
   pull_mode_a: assert property (q == 2'h3 |-> dac_off_pull == gen[2:1])
      else $error("pull mode wrong");
   ref_sel_a: assert property (q == 2'h3 |-> ext_ref_sel == gen[8])
      else $error("reference wrong");
   reset_zero_a: assert property ($past(reset) |-> pin_oe == 12'h000 && !ext_ref_sel)
      else $error("reset state wrong");
endmodule
bind digital_io_config_bank io_cfg_props props (.ref_clk, .reset, .cfg_write, .cfg_sub_addr,
   .cfg_write_data, .gpio_data, .pin_in, .pin_out, .pin_oe, .adc_busy, .alarm_a, .alarm_b,
   .dac_load_strobe_in, .dac_off_pull, .ext_ref_sel);
`default_nettype wire

// file: dv/pad_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_board_model (
   input  wire logic [11:0] pin_out,
   input  wire logic [11:0] pin_oe,
   input  wire logic [11:0] board_level,
   output logic      [11:0] pin_in
);
   // Pad level: device driver when enabled, else the board's own level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk = 1'b0, reset = 1'b1, cfg_write = 1'b0, adc_busy = 1'b1, alarm_a = 1'b1;
   logic alarm_b = 1'b0, dac_load_strobe_in, ext_ref_sel;
   logic [7:0] cfg_sub_addr = 8'h00;
   logic [15:0] cfg_write_data = 16'h0000, cfg_read_data;
   logic [11:0] gpio_data = 12'ha5a, board = 12'h00c, pin_in, pin_out, pin_oe, gpio_in;
   logic [3:0] dac_off;
   logic [1:0] dac_off_pull;
   int fail_count = 0, num_checks = 0;
   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;
   digital_io_config_bank dut (.ref_clk, .reset, .cfg_write, .cfg_sub_addr, .cfg_write_data,
      .cfg_read_data, .gpio_data, .pin_in, .pin_out, .pin_oe, .gpio_in, .adc_busy, .alarm_a,
      .alarm_b, .dac_load_strobe_in, .dac_off, .dac_off_pull, .ext_ref_sel);
   pad_board_model brd (.pin_out, .pin_oe, .board_level(board), .pin_in);
   task automatic chk(input string n, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   // Strobe stays up so writes can follow back to back
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk) {cfg_write, cfg_sub_addr, cfg_write_data} <= {1'b1, a, d};
   endtask
   task automatic settle;
      @(posedge ref_clk) cfg_write <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge ref_clk) cfg_sub_addr <= a;
      @(posedge ref_clk);
      @(negedge ref_clk) chk("read", e, cfg_read_data);
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'h02, 16'h0000);
      wr(8'h01, 16'hffff);
      wr(8'h08, 16'h0136);
      wr(8'h30, 16'h0005);
      wr(8'h31, 16'h000a);
      wr(8'h05, 16'hffff);
      settle();
      chk("out", 16'h0a41, {4'h0, pin_out});
      chk("off", 16'h0005, {12'h0, dac_off});
      chk("oe", 16'h0fe3, {4'h0, pin_oe});
      chk("ref", 16'h0001, {15'h0, ext_ref_sel});
      chk("load", 16'h0001, {15'h0, dac_load_strobe_in});
      rd(8'h01, 16'hffff);
      rd(8'h05, 16'h0000);
      wr(8'h02, 16'hffbc);
      adc_busy <= 1'b0;
      wr(8'h08, 16'h0000);
      settle();
      chk("out", 16'h0a1a, {4'h0, pin_out});
      chk("off", 16'h0000, {12'h0, dac_off});
      for (int m = 0; m < 4; m++) begin
         wr(8'h08, 16'(2 * m));
         settle();
         chk("pull", 16'(m), {14'h0, dac_off_pull});
      end
      wr(8'h01, 16'h0000);
      board <= 12'h5a3;
      settle();
      chk("in", 16'h05a3, {4'h0, gpio_in});
      tally_and_finish();
   end
endmodule
`default_nettype wire

// file: logic/digital_io_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
module digital_io_config_bank (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        cfg_write,
   input  wire logic [7:0]  cfg_sub_addr,
   input  wire logic [15:0] cfg_write_data,
   output logic      [15:0] cfg_read_data,
   input  wire logic [11:0] gpio_data,
   input  wire logic [11:0] pin_in,
   output logic      [11:0] pin_out,
   output logic      [11:0] pin_oe,
   output logic      [11:0] gpio_in,
   input  wire logic        adc_busy,
   input  wire logic        alarm_a,
   input  wire logic        alarm_b,
   output logic             dac_load_strobe_in,
   output logic [3:0]       dac_off,
   output logic [1:0]       dac_off_pull,
   output logic             ext_ref_sel
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [15:0] pin_driver_enable;
      logic [15:0] pin_function_select;
      logic [15:0] general_settings;
      logic [15:0] route_a;
      logic [15:0] route_b;
      logic [15:0] read_data;
      logic [11:0] pin_out;
      logic [11:0] pin_oe;
      logic [11:0] gpio_in;
      logic        dac_load;
      logic [3:0]  dac_off;
      logic [1:0]  pull;
      logic        ext_ref;
   } state_type;

   state_type state;
   state_type next_state;

   // Level of an alarm pin for a given polarity setting
   function automatic logic alarm_level(input logic active, input logic high_pol);
      alarm_level = high_pol ? active : ~active;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [11:0] gpio_mode;
      logic        off_a;
      logic        off_b;
      gpio_mode = '0;
      off_a = 1'b0;
      off_b = 1'b0;
      next_state = state;
      // Subregister writes, full 16 bits kept so reserved bits read back
      if (cfg_write) begin
         unique case (cfg_sub_addr)
            io_config_pkg::SUB_DRIVER_ENABLE:   next_state.pin_driver_enable = cfg_write_data;
            io_config_pkg::SUB_FUNCTION_SELECT: next_state.pin_function_select = cfg_write_data;
            io_config_pkg::SUB_GENERAL:         next_state.general_settings = cfg_write_data;
            io_config_pkg::SUB_DAC_OFF_ROUTE_A: next_state.route_a = cfg_write_data;
            io_config_pkg::SUB_DAC_OFF_ROUTE_B: next_state.route_b = cfg_write_data;
            default: ;
         endcase
      end
      // Readback of the addressed subregister
      unique case (cfg_sub_addr)
         io_config_pkg::SUB_DRIVER_ENABLE:   next_state.read_data = state.pin_driver_enable;
         io_config_pkg::SUB_FUNCTION_SELECT: next_state.read_data = state.pin_function_select;
         io_config_pkg::SUB_GENERAL:         next_state.read_data = state.general_settings;
         io_config_pkg::SUB_DAC_OFF_ROUTE_A: next_state.read_data = state.route_a;
         io_config_pkg::SUB_DAC_OFF_ROUTE_B: next_state.read_data = state.route_b;
         default:                            next_state.read_data = 16'h0000;
      endcase
      // Single-role pins are GPIO whatever the host wrote there
      gpio_mode = state.pin_function_select[11:0] | io_config_pkg::SINGLE_ROLE_MASK;
      // Plain GPIO path for every pin
      for (int i = 0; i < io_config_pkg::PIN_COUNT; i++) begin
         next_state.pin_oe[i]  = state.pin_driver_enable[i];
         next_state.pin_out[i] = gpio_mode[i] ? gpio_data[i] : 1'b0;
         next_state.gpio_in[i] = pin_in[i];
      end
      // Busy output on pin 6
      if (!gpio_mode[io_config_pkg::PIN_BUSY]) begin
         next_state.pin_out[io_config_pkg::PIN_BUSY] = adc_busy;
      end
      // Alarm outputs with programmable polarity
      if (!gpio_mode[io_config_pkg::PIN_ALARM_A]) begin
         next_state.pin_out[io_config_pkg::PIN_ALARM_A] = alarm_level(
            alarm_a, state.general_settings[io_config_pkg::GEN_ALARM_A_POL]);
      end
      if (!gpio_mode[io_config_pkg::PIN_ALARM_B]) begin
         next_state.pin_out[io_config_pkg::PIN_ALARM_B] = alarm_level(
            alarm_b, state.general_settings[io_config_pkg::GEN_ALARM_B_POL]);
      end
      // Input functions: driver held off so the pad is listened to
      if (!gpio_mode[io_config_pkg::PIN_DAC_OFF_A]) begin
         next_state.pin_oe[io_config_pkg::PIN_DAC_OFF_A] = 1'b0;
         off_a = pin_in[io_config_pkg::PIN_DAC_OFF_A];
      end
      if (!gpio_mode[io_config_pkg::PIN_DAC_OFF_B]) begin
         next_state.pin_oe[io_config_pkg::PIN_DAC_OFF_B] = 1'b0;
         off_b = pin_in[io_config_pkg::PIN_DAC_OFF_B];
      end
      if (!gpio_mode[io_config_pkg::PIN_DAC_LOAD]) begin
         next_state.pin_oe[io_config_pkg::PIN_DAC_LOAD] = 1'b0;
         next_state.dac_load = pin_in[io_config_pkg::PIN_DAC_LOAD];
      end else begin
         next_state.dac_load = 1'b0;
      end
      // Each DAC-off pin gates the DACs its routing subregister names
      next_state.dac_off = ({4{off_a}} & state.route_a[3:0])
                         | ({4{off_b}} & state.route_b[3:0]);
      // Pull mode follows the general subregister whatever function the DAC-off pins have
      next_state.pull = state.general_settings[io_config_pkg::GEN_DAC_OFF_LSB +: 2];
      next_state.ext_ref = state.general_settings[io_config_pkg::GEN_REF_SEL];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops
   assign cfg_read_data      = state.read_data;
   assign pin_out            = state.pin_out;
   assign pin_oe             = state.pin_oe;
   assign gpio_in            = state.gpio_in;
   assign dac_load_strobe_in = state.dac_load;
   assign dac_off            = state.dac_off;
   assign dac_off_pull       = state.pull;
   assign ext_ref_sel        = state.ext_ref;

endmodule
`default_nettype wire

// file: logic/io_config_pkg.sv
`default_nettype none
package io_config_pkg;
   // Subregister addresses within the configuration bank
   localparam logic [7:0]  SUB_DRIVER_ENABLE   = 8'h01;
   localparam logic [7:0]  SUB_FUNCTION_SELECT = 8'h02;
   localparam logic [7:0]  SUB_GENERAL         = 8'h08;
   localparam logic [7:0]  SUB_DAC_OFF_ROUTE_A = 8'h30;
   localparam logic [7:0]  SUB_DAC_OFF_ROUTE_B = 8'h31;
   // Pin count and reset values
   localparam int          PIN_COUNT           = 12;
   localparam logic [15:0] CONFIG_RESET        = 16'h0000;
   // Single-role pins must be written as one
   localparam logic [11:0] SINGLE_ROLE_MASK    = 12'hfa0;
   // Pin positions of the dual-role functions
   localparam int          PIN_ALARM_A         = 0;
   localparam int          PIN_ALARM_B         = 1;
   localparam int          PIN_DAC_OFF_A       = 2;
   localparam int          PIN_DAC_LOAD        = 3;
   localparam int          PIN_DAC_OFF_B       = 4;
   localparam int          PIN_BUSY            = 6;
   // General subregister field positions
   localparam int          GEN_DAC_OFF_LSB     = 1;
   localparam int          GEN_ALARM_A_POL     = 4;
   localparam int          GEN_ALARM_B_POL     = 5;
   localparam int          GEN_REF_SEL         = 8;
   // Pull-down modes of the DAC-off pins
   localparam logic [1:0]  PULL_BOTH           = 2'h0;
   localparam logic [1:0]  PULL_WEAK           = 2'h1;
   localparam logic [1:0]  PULL_STRONG         = 2'h2;
   localparam logic [1:0]  PULL_HIGH_Z         = 2'h3;
   // Number of DAC outputs a DAC-off pin can gate
   localparam int          DAC_COUNT           = 4;
endpackage
`default_nettype wire
